// ==== logic/imc_pkg.sv ====
`default_nettype none
package imc_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IRQEN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0c;
  // ==========================================================
  // control fields
  localparam int CTRL_IDLE_BIT = 0;
  localparam int CTRL_SEL_LO = 1;
  localparam int CTRL_SECEN_BIT = 3;
  localparam int CTRL_GIE_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] IRQEN_RESET = 8'h00;
  localparam int CMD_SLEEP_BIT = 0;
  // ==========================================================
  // status fields
  localparam int STAT_PRI_BIT = 0;
  localparam int STAT_SEC_BIT = 1;
  localparam int STAT_CPU_BIT = 2;
  localparam int STAT_PER_BIT = 3;
  localparam int STAT_MODE_LO = 4;
  // ==========================================================
  // primary oscillator configuration codes
  localparam logic [3:0] OSC_XT = 4'h0;
  localparam logic [3:0] OSC_HS = 4'h1;
  localparam logic [3:0] OSC_CRYSTAL_PLL_MODE = 4'h2;
  localparam logic [3:0] OSC_HIGHSPEED_PLL_MODE = 4'h3;
  localparam logic [3:0] OSC_EC = 4'h4;
  // ==========================================================
  // timing counts in core_clk cycles
  localparam int CSD_CYCLES_DEF = 16;
  localparam int OST_CYCLES_DEF = 1024;
  localparam int PLL_CYCLES_DEF = 256;
  localparam int CNT_W = 16;
  // ==========================================================
  // clock sources and controller states
  typedef enum logic [1:0] {
    SRC_PRI = 2'b00,
    SRC_SEC = 2'b01,
    SRC_RC = 2'b10,
    SRC_NONE = 2'b11
  } imc_src_e;
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_RUN = 3'b001,
    ST_IDLE = 3'b010,
    ST_SLEEP = 3'b011,
    ST_WAKE = 3'b100
  } imc_state_e;
endpackage : imc_pkg
`default_nettype wire

// ==== logic/imc_idle_wake_ctrl.sv ====
// Function
// - primary idle: cpu clock off, peripherals on primary, primary flag kept
// - primary idle wake: cpu on primary after ready delay, flags kept
// - secondary idle: peripherals on secondary, primary off, flags swap
// - sleep ignored if secondary idle chosen and secondary osc disabled
// - peripheral clocks withheld until secondary oscillator is running
// - secondary idle wake: cpu resumes on secondary after ready delay
// - internal idle: upper select set, lower ignored, primary stopped
// - internal idle wake on rc clock; rc kept if watchdog/fail-safe
// - enabled interrupt with flag set starts exit from idle or sleep
// - irq wake jumps to vector if global enable, else continues
// - every exit from idle or sleep waits the cpu-ready delay, then execution resumes
// - watchdog time-out wakes in idle/sleep, resets in run
// - reset exit held by start-up timer until primary ready
// - two-speed or fail-safe: run on rc until primary ready
// - no start-up timer from primary idle or non-crystal primary
// - sleep wake delay by mode: timer, timer plus lock, or ready delay
// - cpu-ready delay runs concurrently with other start-up delays
// - waking to rc clock continues during rc stabilization
// - idle bit at sleep command picks sleep or matching idle mode
// - sleep stops primary oscillator and clears clock status flags
`timescale 1ns/1ps
`default_nettype none
module imc_idle_wake_ctrl #(
  parameter int IRQ_NUM = 8,
  parameter int CSD_CYCLES = imc_pkg::CSD_CYCLES_DEF,
  parameter int OST_CYCLES = imc_pkg::OST_CYCLES_DEF,
  parameter int PLL_CYCLES = imc_pkg::PLL_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic [IRQ_NUM-1:0] irqFlag,
  input wire logic wdtTimeout,
  input wire logic secOscRunning,
  input wire logic [3:0] primaryOscConfig,
  input wire logic wdtEnable,
  input wire logic failSafeEnable,
  input wire logic twoSpeedEnable,
  output logic cpuClkEn,
  output logic periphClkEn,
  output logic [1:0] clkSrc,
  output logic primaryOscEn,
  output logic secondaryOscEn,
  output logic internalRcEn,
  output logic wdtResetReq,
  output logic vectorJump,
  output logic resumeNext
);
  // ==========================================================
  // elaboration checks
  generate
    if (IRQ_NUM < 1 || IRQ_NUM > 8) begin : g_bad_irq
      $error("IRQ_NUM must be 1 to 8");
    end
    if (CSD_CYCLES < 1 || OST_CYCLES < 1 || PLL_CYCLES < 1)
    begin : g_bad_cnt
      $error("cycle counts must be at least 1");
    end
    if (OST_CYCLES + PLL_CYCLES > 65535) begin : g_bad_sum
      $error("start-up plus lock count exceeds counter");
    end
  endgenerate

  localparam logic [15:0] CSD_LAST = 16'(CSD_CYCLES - 1);
  localparam logic [15:0] OST_N = 16'(OST_CYCLES);
  localparam logic [15:0] OSTPLL_N = 16'(OST_CYCLES + PLL_CYCLES);

  // ==========================================================
  // declarations
  imc_pkg::imc_state_e state_ff;
  imc_pkg::imc_src_e src_ff;
  imc_pkg::imc_src_e selSrc;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic idleOnSleep_ff;
  logic [1:0] clockSelect_ff;
  logic secOscEnable_ff;
  logic globalIrqEnable_ff;
  logic [IRQ_NUM-1:0] irqEnable_ff;
  logic secMeta_ff;
  logic secSync_ff;
  logic [15:0] priCnt_ff;
  logic [15:0] csdCnt_ff;
  logic priOscEn_ff;
  logic priRun_ff;
  logic secRun_ff;
  logic wakeIrq_ff;
  logic cpuClkEn_ff;
  logic periphClkEn_ff;
  logic [1:0] clkSrc_ff;
  logic intRcEn_ff;
  logic secOscEn_ff;
  logic wdtReset_ff;
  logic vector_ff;
  logic resume_ff;
  logic busReq;
  logic busWr;
  logic sleepCmd;
  logic [15:0] priNeed;
  logic priReady;
  logic csdDone;
  logic irqHit;
  logic wakeEvt;
  logic srcOk;
  logic earlyRc;
  logic [31:0] rdData;

  // ==========================================================
  // combinational decode
  assign busReq = wb_cyc_i && wb_stb_i && !ack_ff;
  assign busWr = busReq && wb_we_i && wb_sel_i[0];
  assign sleepCmd = busWr && (wb_adr_i == imc_pkg::ADDR_CMD) &&
                    wb_dat_i[imc_pkg::CMD_SLEEP_BIT];
  // lower select bit is a don't care once the upper one is set
  assign selSrc = clockSelect_ff[1] ? imc_pkg::SRC_RC :
                  (clockSelect_ff[0] ? imc_pkg::SRC_SEC :
                   imc_pkg::SRC_PRI);
  assign irqHit = |(irqFlag & irqEnable_ff);
  assign wakeEvt = irqHit || wdtTimeout;
  assign earlyRc = twoSpeedEnable || failSafeEnable;
  assign csdDone = (csdCnt_ff >= CSD_LAST);
  assign priReady = priOscEn_ff && (priCnt_ff >= priNeed);

  always_comb begin
    case (primaryOscConfig)
      imc_pkg::OSC_XT, imc_pkg::OSC_HS: priNeed = OST_N;
      imc_pkg::OSC_CRYSTAL_PLL_MODE, imc_pkg::OSC_HIGHSPEED_PLL_MODE: priNeed = OSTPLL_N;
      default: priNeed = 16'h0000;
    endcase
  end

  always_comb begin
    unique case (src_ff)
      imc_pkg::SRC_PRI: srcOk = priReady;
      imc_pkg::SRC_SEC: srcOk = secSync_ff;
      imc_pkg::SRC_RC: srcOk = 1'b1;
      imc_pkg::SRC_NONE: srcOk = 1'b0;
    endcase
  end

  always_comb begin
    rdData = 32'h0000_0000;
    case (wb_adr_i)
      imc_pkg::ADDR_CTRL: begin
        rdData[imc_pkg::CTRL_IDLE_BIT] = idleOnSleep_ff;
        rdData[imc_pkg::CTRL_SEL_LO +: 2] = clockSelect_ff;
        rdData[imc_pkg::CTRL_SECEN_BIT] = secOscEnable_ff;
        rdData[imc_pkg::CTRL_GIE_BIT] = globalIrqEnable_ff;
      end
      imc_pkg::ADDR_IRQEN: rdData[IRQ_NUM-1:0] = irqEnable_ff;
      imc_pkg::ADDR_STATUS: begin
        rdData[imc_pkg::STAT_PRI_BIT] = priRun_ff;
        rdData[imc_pkg::STAT_SEC_BIT] = secRun_ff;
        rdData[imc_pkg::STAT_CPU_BIT] = cpuClkEn_ff;
        rdData[imc_pkg::STAT_PER_BIT] = periphClkEn_ff;
        rdData[imc_pkg::STAT_MODE_LO +: 3] = state_ff;
      end
      default: rdData = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // wishbone slave, one wait state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= busReq;
      if (busReq && !wb_we_i) begin
        dat_ff <= rdData;
      end
    end
  end

  // ==========================================================
  // firmware control bits; wake leaves them untouched
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idleOnSleep_ff <= imc_pkg::CTRL_RESET[imc_pkg::CTRL_IDLE_BIT];
      clockSelect_ff <= imc_pkg::CTRL_RESET[imc_pkg::CTRL_SEL_LO +: 2];
      secOscEnable_ff <= imc_pkg::CTRL_RESET[imc_pkg::CTRL_SECEN_BIT];
      globalIrqEnable_ff <= imc_pkg::CTRL_RESET[imc_pkg::CTRL_GIE_BIT];
      irqEnable_ff <= imc_pkg::IRQEN_RESET[IRQ_NUM-1:0];
    end else if (busWr) begin
      if (wb_adr_i == imc_pkg::ADDR_CTRL) begin
        idleOnSleep_ff <= wb_dat_i[imc_pkg::CTRL_IDLE_BIT];
        clockSelect_ff <= wb_dat_i[imc_pkg::CTRL_SEL_LO +: 2];
        secOscEnable_ff <= wb_dat_i[imc_pkg::CTRL_SECEN_BIT];
        globalIrqEnable_ff <= wb_dat_i[imc_pkg::CTRL_GIE_BIT];
      end
      if (wb_adr_i == imc_pkg::ADDR_IRQEN) begin
        irqEnable_ff <= wb_dat_i[IRQ_NUM-1:0];
      end
    end
  end

  // ==========================================================
  // secondary oscillator running pin synchroniser
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      secMeta_ff <= 1'b0;
      secSync_ff <= 1'b0;
    end else begin
      secMeta_ff <= secOscRunning;
      secSync_ff <= secMeta_ff;
    end
  end

  // ==========================================================
  // primary start-up timer and pll lock
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      priCnt_ff <= 16'h0000;
    end else if (!priOscEn_ff) begin
      priCnt_ff <= 16'h0000;
    end else if (!priReady) begin
      priCnt_ff <= priCnt_ff + 16'h0001;
    end
  end

  // ==========================================================
  // cpu-ready delay, counted alongside the start-up timer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      csdCnt_ff <= 16'h0000;
    end else if (state_ff != imc_pkg::ST_WAKE) begin
      csdCnt_ff <= 16'h0000;
    end else if (!csdDone) begin
      csdCnt_ff <= csdCnt_ff + 16'h0001;
    end
  end

  // ==========================================================
  // power mode sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= imc_pkg::ST_RESET;
      src_ff <= imc_pkg::SRC_PRI;
      priOscEn_ff <= 1'b1;
      priRun_ff <= 1'b0;
      secRun_ff <= 1'b0;
      wakeIrq_ff <= 1'b0;
      wdtReset_ff <= 1'b0;
      vector_ff <= 1'b0;
      resume_ff <= 1'b0;
    end else begin
      wdtReset_ff <= 1'b0;
      vector_ff <= 1'b0;
      resume_ff <= 1'b0;
      unique case (state_ff)
        imc_pkg::ST_RESET: begin
          if (earlyRc) begin
            state_ff <= imc_pkg::ST_RUN;
            src_ff <= imc_pkg::SRC_RC;
          end else if (priReady) begin
            state_ff <= imc_pkg::ST_RUN;
            priRun_ff <= 1'b1;
          end
        end
        imc_pkg::ST_RUN: begin
          if (wdtTimeout) begin
            wdtReset_ff <= 1'b1;
          end else if (sleepCmd && idleOnSleep_ff) begin
            if (selSrc == imc_pkg::SRC_SEC && !secOscEnable_ff) begin
              state_ff <= imc_pkg::ST_RUN;
            end else begin
              state_ff <= imc_pkg::ST_IDLE;
              src_ff <= selSrc;
              priOscEn_ff <= (selSrc == imc_pkg::SRC_PRI);
              priRun_ff <= (selSrc == imc_pkg::SRC_PRI) &&
                           priReady;
              secRun_ff <= (selSrc == imc_pkg::SRC_SEC);
            end
          end else if (sleepCmd) begin
            state_ff <= imc_pkg::ST_SLEEP;
            src_ff <= imc_pkg::SRC_NONE;
            priOscEn_ff <= 1'b0;
            priRun_ff <= 1'b0;
            secRun_ff <= 1'b0;
          end else if (selSrc == imc_pkg::SRC_PRI) begin
            if (src_ff != imc_pkg::SRC_PRI) begin
              priOscEn_ff <= 1'b1;
              if (priReady) begin
                src_ff <= imc_pkg::SRC_PRI;
                priRun_ff <= 1'b1;
                secRun_ff <= 1'b0;
              end
            end
          end else if (selSrc == imc_pkg::SRC_SEC) begin
            if (src_ff != imc_pkg::SRC_SEC && secOscEnable_ff) begin
              src_ff <= imc_pkg::SRC_SEC;
              priOscEn_ff <= 1'b0;
              priRun_ff <= 1'b0;
              secRun_ff <= 1'b1;
            end
          end else if (src_ff != imc_pkg::SRC_RC) begin
            src_ff <= imc_pkg::SRC_RC;
            priOscEn_ff <= 1'b0;
            priRun_ff <= 1'b0;
            secRun_ff <= 1'b0;
          end
        end
        imc_pkg::ST_IDLE: begin
          // source kept, so the cpu resumes on the idle clock
          if (wakeEvt) begin
            state_ff <= imc_pkg::ST_WAKE;
            wakeIrq_ff <= irqHit;
          end
        end
        imc_pkg::ST_SLEEP: begin
          if (wakeEvt) begin
            state_ff <= imc_pkg::ST_WAKE;
            wakeIrq_ff <= irqHit;
            if (selSrc == imc_pkg::SRC_PRI) begin
              priOscEn_ff <= 1'b1;
              src_ff <= earlyRc ? imc_pkg::SRC_RC :
                        imc_pkg::SRC_PRI;
            end else if (selSrc == imc_pkg::SRC_SEC &&
                         secOscEnable_ff) begin
              src_ff <= imc_pkg::SRC_SEC;
              secRun_ff <= 1'b1;
            end else begin
              src_ff <= imc_pkg::SRC_RC;
            end
          end
        end
        imc_pkg::ST_WAKE: begin
          if (csdDone && (src_ff != imc_pkg::SRC_PRI || priReady))
          begin
            state_ff <= imc_pkg::ST_RUN;
            if (src_ff == imc_pkg::SRC_PRI) begin
              priRun_ff <= 1'b1;
            end
            vector_ff <= wakeIrq_ff && globalIrqEnable_ff;
            resume_ff <= !(wakeIrq_ff && globalIrqEnable_ff);
          end
        end
        default: begin
          state_ff <= imc_pkg::ST_RESET;
        end
      endcase
    end
  end

  // ==========================================================
  // registered clock gates and oscillator enables
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpuClkEn_ff <= 1'b0;
      periphClkEn_ff <= 1'b0;
      clkSrc_ff <= 2'h0;
      intRcEn_ff <= 1'b0;
      secOscEn_ff <= 1'b0;
    end else begin
      // secondary kept running while it still clocks the core
      secOscEn_ff <= secOscEnable_ff ||
                     (src_ff == imc_pkg::SRC_SEC);
      cpuClkEn_ff <= (state_ff == imc_pkg::ST_RUN) && srcOk;
      periphClkEn_ff <= (state_ff == imc_pkg::ST_RUN ||
                         state_ff == imc_pkg::ST_IDLE ||
                         state_ff == imc_pkg::ST_WAKE) && srcOk;
      clkSrc_ff <= src_ff;
      intRcEn_ff <= (src_ff == imc_pkg::SRC_RC) || wdtEnable ||
                    failSafeEnable;
    end
  end

  // ==========================================================
  // outputs
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign cpuClkEn = cpuClkEn_ff;
  assign periphClkEn = periphClkEn_ff;
  assign clkSrc = clkSrc_ff;
  assign primaryOscEn = priOscEn_ff;
  assign secondaryOscEn = secOscEn_ff;
  assign internalRcEn = intRcEn_ff;
  assign wdtResetReq = wdtReset_ff;
  assign vectorJump = vector_ff;
  assign resumeNext = resume_ff;
endmodule : imc_idle_wake_ctrl
`default_nettype wire

// ==== testbench/imc_idle_wake_ctrl_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module imc_idle_wake_ctrl_props #(
  parameter int CSD_CYCLES = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wdtTimeout,
  input wire logic secOscRunning,
  input wire logic cpuClkEn,
  input wire logic periphClkEn,
  input wire logic [1:0] clkSrc,
  input wire logic primaryOscEn,
  input wire logic secondaryOscEn,
  input wire logic wdtResetReq,
  input wire logic vectorJump,
  input wire logic resumeNext
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========
  // bus
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  // ==========
  // resume and clocks
  a_resume_kind: assert property (!(vectorJump && resumeNext))
    else $error("both resume pulses");
  a_cpu_after_resume: assert property ((vectorJump || resumeNext)
    |=> cpuClkEn && !vectorJump && !resumeNext)
    else $error("cpu clock not resumed");
  a_wdt_req_cause: assert property (wdtResetReq
    |-> wdtTimeout || $past(wdtTimeout))
    else $error("reset request without time-out");
  a_wdt_idle_wake: assert property ((periphClkEn && !cpuClkEn)[*2]
    |-> !wdtResetReq)
    else $error("reset request while idle");
  a_sec_needs_en: assert property (clkSrc == imc_pkg::SRC_SEC
    |-> secondaryOscEn)
    else $error("secondary source without enable");
  a_sec_periph_wait: assert property (periphClkEn &&
    clkSrc == imc_pkg::SRC_SEC |-> $past(secOscRunning, 2))
    else $error("peripheral clock before oscillator");
  a_primary_idle_on: assert property (periphClkEn && !cpuClkEn &&
    clkSrc == imc_pkg::SRC_PRI |-> primaryOscEn)
    else $error("primary stopped in primary idle");
  a_internal_idle_off: assert property ((periphClkEn && !cpuClkEn &&
    clkSrc == imc_pkg::SRC_RC)[*2] |-> !primaryOscEn)
    else $error("primary running in internal idle");
endmodule : imc_idle_wake_ctrl_props
bind imc_idle_wake_ctrl imc_idle_wake_ctrl_props #(
  .CSD_CYCLES(CSD_CYCLES)
) u_props (
  .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wdtTimeout(wdtTimeout),
  .secOscRunning(secOscRunning), .cpuClkEn(cpuClkEn),
  .periphClkEn(periphClkEn), .clkSrc(clkSrc),
  .primaryOscEn(primaryOscEn), .secondaryOscEn(secondaryOscEn),
  .wdtResetReq(wdtResetReq), .vectorJump(vectorJump),
  .resumeNext(resumeNext)
);
`default_nettype wire

// ==== testbench/imc_sec_osc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module imc_sec_osc_model #(
  parameter int START = 6
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic secondaryOscEn,
  output logic secOscRunning
);
  // ==========
  // start-up delay, stops when disabled
  int cnt_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 0;
      secOscRunning <= 1'b0;
    end else if (!secondaryOscEn) begin
      cnt_ff <= 0;
      secOscRunning <= 1'b0;
    end else begin
      if (cnt_ff < START) cnt_ff <= cnt_ff + 1;
      secOscRunning <= (cnt_ff >= START);
    end
  end
endmodule : imc_sec_osc_model
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int CSD = 4, OSC_STARTUP_TIMER = 16, PLL = 4;
  logic core_clk, rst, cyc, stb, we, ack, wdt, secRun, tsEn, wdtEn;
  logic cpuEn, perEn, priEn, secEn, rcEn, wdtReq, vj, rn;
  logic [7:0] adr, irq;
  logic [31:0] wdat, rdat;
  logic [3:0] cfg;
  logic [1:0] src;
  int err_count, n_checks, cycN;
  imc_idle_wake_ctrl #(.CSD_CYCLES(CSD), .OST_CYCLES(OSC_STARTUP_TIMER),
    .PLL_CYCLES(PLL)) u_dut (.core_clk(core_clk), .rst(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'h1), .wb_ack_o(ack), .wb_dat_o(rdat),
    .irqFlag(irq), .wdtTimeout(wdt), .secOscRunning(secRun),
    .primaryOscConfig(cfg), .wdtEnable(wdtEn), .failSafeEnable(1'b0),
    .twoSpeedEnable(tsEn), .cpuClkEn(cpuEn), .periphClkEn(perEn),
    .clkSrc(src), .primaryOscEn(priEn), .secondaryOscEn(secEn),
    .internalRcEn(rcEn), .wdtResetReq(wdtReq), .vectorJump(vj),
    .resumeNext(rn));
  imc_sec_osc_model u_osc (.core_clk(core_clk), .rst(rst),
    .secondaryOscEn(secEn), .secOscRunning(secRun));
  // ==========
  // helpers
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  function logic [31:0] sx(input logic p, s, c, q, input logic [2:0] m);
    return {25'h0, m, q, c, s, p};
  endfunction : sx
  function int dly(input logic [3:0] c);
    if (c == imc_pkg::OSC_XT || c == imc_pkg::OSC_HS) return OSC_STARTUP_TIMER;
    if (c == imc_pkg::OSC_CRYSTAL_PLL_MODE || c == imc_pkg::OSC_HIGHSPEED_PLL_MODE)
      return OSC_STARTUP_TIMER + PLL;
    return CSD;
  endfunction : dly
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do @(posedge core_clk); while (ack !== 1'b1);
    cyc <= 0; stb <= 0; we <= 0;
  endtask : wb
  task stat(input string nm, input logic [31:0] e);
    wb(0, imc_pkg::ADDR_STATUS, 0);
    chk(nm, e, rdat);
  endtask : stat
  task waitp(output int n, output logic k);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      k = vj;
    end while (vj !== 1'b1 && rn !== 1'b1 && n < 4000);
  endtask : waitp
  task waitrun(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (cpuEn !== 1'b1 && n < 4000);
  endtask : waitrun
  task reset(input logic [3:0] c, input logic t);
    rst <= 1; cfg <= c; tsEn <= t;
    repeat (6) @(posedge core_clk);
    rst <= 0;
  endtask : reset
  task pulse_wdt;
    wdt <= 1;
    @(posedge core_clk);
    wdt <= 0;
  endtask : pulse_wdt
  // ==========
  // clock and timeout
  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycN++;
    if (cycN == 60000) begin
      err_count++;
      summarize();
    end
  end
  // ==========
  // tests
  initial begin
    int n, b;
    logic k;
    logic [7:0] c;
    logic [3:0] cf[3];
    rst = 1; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; irq = 0;
    wdt = 0; tsEn = 0; wdtEn = 1; cfg = imc_pkg::OSC_XT;
    err_count = 0; n_checks = 0; cycN = 0;
    cf = '{imc_pkg::OSC_XT, imc_pkg::OSC_HIGHSPEED_PLL_MODE, imc_pkg::OSC_EC};
    void'($urandom(56));
    reset(imc_pkg::OSC_XT, 0);
    waitrun(n);
    chk("ost hold", 1, n >= OSC_STARTUP_TIMER);
    stat("run", sx(1, 0, 1, 1, 1));
    wb(0, imc_pkg::ADDR_CTRL, 0);
    chk("ctrl reset", {24'h0, imc_pkg::CTRL_RESET}, rdat);
    wb(0, 8'h10, 0);
    chk("unmapped", 0, rdat);
    $display("test reset done");
    for (int g = 0; g < 2; g++) begin
      b = $urandom % 8;
      c = 8'h01 | (8'(g) << 7);
      wb(1, imc_pkg::ADDR_IRQEN, 32'h1 << b);
      wb(1, imc_pkg::ADDR_CTRL, {24'h0, c});
      wb(1, imc_pkg::ADDR_CMD, 1);
      stat("primary_idle", sx(1, 0, 0, 1, 2));
      irq <= 8'h1 << ((b + 1) % 8);
      repeat ($urandom % 8 + 2) @(posedge core_clk);
      stat("masked irq", sx(1, 0, 0, 1, 2));
      irq <= 8'h1 << b;
      waitp(n, k);
      irq <= 0;
      chk("pri wake", 1, n >= CSD && n <= CSD + 2);
      chk("vector", g, k);
      stat("primary_run", sx(1, 0, 1, 1, 1));
      wb(0, imc_pkg::ADDR_CTRL, 0);
      chk("ctrl kept", {24'h0, c}, rdat);
    end
    $display("test primary idle done");
    wb(1, imc_pkg::ADDR_CTRL, 32'h03);
    wb(1, imc_pkg::ADDR_CMD, 1);
    stat("sec refused", sx(1, 0, 1, 1, 1));
    wb(1, imc_pkg::ADDR_CTRL, 32'h0b);
    repeat (20) @(posedge core_clk);
    wb(1, imc_pkg::ADDR_CMD, 1);
    stat("secondary_idle", sx(0, 1, 0, 1, 2));
    chk("sec src", imc_pkg::SRC_SEC, src);
    pulse_wdt();
    waitp(n, k);
    chk("wdt wake", 0, k);
    stat("secondary_run", sx(0, 1, 1, 1, 1));
    chk("sec osc on", 1, secEn);
    $display("test secondary idle done");
    wb(1, imc_pkg::ADDR_IRQEN, 1);
    wb(1, imc_pkg::ADDR_CTRL, 32'h07);
    wb(1, imc_pkg::ADDR_CMD, 1);
    stat("internal_idle", sx(0, 0, 0, 1, 2));
    chk("pri off", 0, priEn);
    irq <= 1;
    waitp(n, k);
    irq <= 0;
    waitrun(n);
    chk("rc src", imc_pkg::SRC_RC, src);
    chk("rc kept", 1, rcEn);
    pulse_wdt();
    n = 0;
    while (wdtReq !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      n++;
    end
    chk("wdt reset", 1, wdtReq);
    $display("test internal idle done");
    for (int i = 0; i < 3; i++) begin
      wdtEn <= 0;
      reset(cf[i], 0);
      waitrun(n);
      wb(1, imc_pkg::ADDR_IRQEN, 1);
      wb(1, imc_pkg::ADDR_CMD, 1);
      stat("sleep", sx(0, 0, 0, 0, 3));
      irq <= 1;
      waitp(n, k);
      irq <= 0;
      chk("sleep wake", 1, n >= dly(cf[i]) && n <= dly(cf[i]) + 3);
      stat("sleep run", sx(1, 0, 1, 1, 1));
      chk("rc off", 0, rcEn);
    end
    $display("test sleep done");
    reset(imc_pkg::OSC_XT, 1);
    waitrun(n);
    chk("rc start", 1, n < OSC_STARTUP_TIMER);
    stat("rc early", sx(0, 0, 1, 1, 1));
    chk("rc on", 1, rcEn);
    repeat (OSC_STARTUP_TIMER + 4) @(posedge core_clk);
    stat("pri later", sx(1, 0, 1, 1, 1));
    chk("rc stop", 0, rcEn);
    $display("test two-speed done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
